// ---- rtl/oec_pkg.sv ----
// Package of register map, field layout and timing constants for oec block
package oec_pkg;
  // Register byte offsets
  localparam logic [7:0] MPX_CTRL_OFF   = 8'h00;
  localparam logic [7:0] C32_CTRL_OFF   = 8'h04;
  localparam logic [7:0] I32_CTRL_OFF   = 8'h08;
  localparam logic [7:0] STATUS_OFF     = 8'h0C;
  localparam logic [7:0] INT_FLAG_OFF   = 8'h10;
  localparam logic [7:0] INT_MASK_OFF   = 8'h14;
  localparam logic [7:0] SLEEP_CTRL_OFF = 8'h18;
  // Control fields (same layout in all three oscillator registers)
  localparam int ENABLE_BIT  = 1;
  localparam int XTAL_BIT    = 2;
  localparam int OUTPUT_32K_ENABLE_BIT   = 3;
  localparam int AUTO_AMPLITUDE_CONTROL_BIT   = 4;
  localparam int ONDEM_BIT   = 7;
  localparam int GAIN_LSB    = 8;
  localparam int STARTUP_LSB = 12;
  localparam int CALIBRATION_VALUE_LSB   = 16;
  localparam int GAIN_W      = 3;
  localparam int STARTUP_W   = 4;
  localparam int CALIBRATION_VALUE_W     = 7;
  // Status / interrupt bit positions
  localparam int MPX_RDY_BIT = 0;
  localparam int C32_RDY_BIT = 1;
  localparam int I32_RDY_BIT = 2;
  // Sleep control field values
  localparam logic [1:0] SLEEP_ACTIVE  = 2'h0;
  localparam logic [1:0] SLEEP_IDLE    = 2'h1;
  localparam logic [1:0] SLEEP_STANDBY = 2'h2;
  // Reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0080;
  // Start-up time base: one step of STARTUP doubles the count
  localparam int STARTUP_BASE_NS  = 3200;
  localparam int CLK_PERIOD_NS    = 100;
  localparam int STARTUP_BASE_CYC =
    (STARTUP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
endpackage

// ---- rtl/oec_top.sv ----
// Oscillator enable, start-up masking, ready flags and interrupt control
//
// How it works
// [RULE1] Oscillator runs only while enable bit set
// [RULE2] Idle: on-demand bit gates run by request
// [RULE3] Ultra-low-power oscillator always runs, standby stops multipurpose and internal 32k
// [RULE4] Multipurpose oscillator disabled after reset, pins free
// [RULE5] Crystal takes both pins, external input only
// [RULE6] Crystal select one crystal, zero external clock
// [RULE7] Software sets gain to crystal frequency
// [RULE8] Amplitude control bit enables automatic amplitude
// [RULE9] Output masked during start-up after reset/wake
// [RULE10] Ready after start-up; rising edge raises interrupt
// [RULE11] 32k crystal disabled at power-on, pins free
// [RULE12] Software disables 32k crystal touching enable only
// [RULE13] Enabled 32k crystal stays on in sleep
// [RULE14] 32k crystal survives all resets but power-on
// [RULE15] 32k output enable, crystal mode only
// [RULE16] Internal 32k needs enable and output enable
// [RULE17] Internal 32k clock passes only when ready
// [RULE18] Calibration committed when internal ready rises
// [RULE19] Disabling an oscillator clears its ready flag
`timescale 1ns/1ps
`default_nettype none
module oec_top #(
  parameter int CNT_W = oec_pkg::CNT_W
) (
  // Clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral clock requests, one per oscillator
  input  wire logic [2:0]  clk_request,
  // Oscillator controls
  output logic             mpx_osc_run,
  output logic             mpx_clk_gate,
  output logic             mpx_crystal_input_pin_ovr,
  output logic             mpx_crystal_output_pin_ovr,
  output logic             mpx_xtal_mode,
  output logic             mpx_auto_amp,
  output logic [2:0]       mpx_gain,
  output logic             c32_osc_run,
  output logic             c32_clk_gate,
  output logic             c32_out_32k_en,
  output logic             slow_crystal_input_pin_ovr,
  output logic             slow_crystal_output_pin_ovr,
  output logic             i32_osc_run,
  output logic             i32_clk_gate,
  output logic [6:0]       i32_calibration_value,
  output logic             ulp_osc_run,
  // Interrupt
  output logic             irq
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0]      mpx_ctrl;
    logic [31:0]      i32_ctrl;
    logic [1:0]       sleep;
    logic [2:0]       rdy;
    logic [2:0]       flag;
    logic [2:0]       mask;
    logic [2:0]       run;
    logic [CNT_W-1:0] cnt_m;
    logic [CNT_W-1:0] cnt_i;
    logic [6:0]       calibration_value;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
    logic             mpx_oovr;
  } oec_state_s;

  // 32k crystal state lives apart: reset only by power-on
  typedef struct packed {
    logic [31:0]      c32_ctrl;
    logic             rdy;
    logic             run;
    logic [CNT_W-1:0] cnt;
    logic             rdy_seen;
    logic             oovr;
    logic             out32;
    logic             ulp;
  } oec_c32_s;

  oec_state_s s_q, s_d;
  oec_c32_s   c_q, c_d;

  // Start-up length in cycles from a start-up field
  function automatic logic [CNT_W-1:0] oec_su_len(input logic [3:0] f);
    oec_su_len = CNT_W'(oec_pkg::STARTUP_BASE_CYC) << f;
  endfunction

  // Run decision for an ordinary oscillator in the present sleep state
  function automatic logic oec_runs(input logic en, input logic ondem,
                                    input logic req, input logic [1:0] sl);
    logic r;
    r = 1'b0;
    case (sl)
      oec_pkg::SLEEP_ACTIVE:  r = en;                       // RULE1
      oec_pkg::SLEEP_IDLE:    r = en & (~ondem | req);      // RULE2
      default:                r = 1'b0;                     // RULE3
    endcase
    oec_runs = r;
  endfunction

  logic wr_en;
  logic rd_en;
  assign wr_en = psel & penable & pwrite & ~s_q.pready;
  assign rd_en = psel & penable & ~pwrite & ~s_q.pready;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // Main domain: bus, multipurpose and internal oscillators, interrupts
  always_comb begin
    logic [2:0] rise;
    logic [2:0] rdy_all;
    logic       map_hit;
    logic       i32_en;
    rise     = 3'h0;
    rdy_all  = 3'h0;
    map_hit  = 1'b0;
    i32_en   = 1'b0;
    s_d      = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;

    // Register writes
    if (wr_en) begin
      case (paddr)
        oec_pkg::MPX_CTRL_OFF:   s_d.mpx_ctrl = pwdata;
        oec_pkg::I32_CTRL_OFF:   s_d.i32_ctrl = pwdata;
        oec_pkg::C32_CTRL_OFF:   map_hit = 1'b1;
        oec_pkg::INT_MASK_OFF:   s_d.mask = pwdata[2:0];
        oec_pkg::SLEEP_CTRL_OFF: s_d.sleep = pwdata[1:0];
        oec_pkg::INT_FLAG_OFF:   s_d.flag = s_q.flag & ~pwdata[2:0];
        oec_pkg::STATUS_OFF:     map_hit = 1'b1;
        default:                 s_d.pslverr = 1'b1;
      endcase
      s_d.pready = 1'b1;
    end

    // Multipurpose oscillator run and start-up masking
    s_d.run[0] = oec_runs(s_q.mpx_ctrl[oec_pkg::ENABLE_BIT],
                          s_q.mpx_ctrl[oec_pkg::ONDEM_BIT],
                          clk_request[0], s_q.sleep);           // RULE1
    if (!s_d.run[0]) begin
      s_d.rdy[0] = 1'b0;                                        // RULE19
      s_d.cnt_m  = '0;
    end else if (!s_q.run[0]) begin
      s_d.cnt_m  = oec_su_len(
        s_q.mpx_ctrl[oec_pkg::STARTUP_LSB +: oec_pkg::STARTUP_W]); // RULE9
      s_d.rdy[0] = 1'b0;
    end else if (s_q.cnt_m != '0) begin
      s_d.cnt_m = s_q.cnt_m - 1'b1;
    end else begin
      s_d.rdy[0] = 1'b1;                                        // RULE10
    end
    // Registered so the pad override never glitches on a decode
    s_d.mpx_oovr = s_d.run[0] & s_d.mpx_ctrl[oec_pkg::XTAL_BIT];  // RULE5

    // Internal 32k needs both enable and output enable
    i32_en = s_q.i32_ctrl[oec_pkg::ENABLE_BIT] &
             s_q.i32_ctrl[oec_pkg::OUTPUT_32K_ENABLE_BIT];                  // RULE16
    s_d.run[2] = oec_runs(i32_en, s_q.i32_ctrl[oec_pkg::ONDEM_BIT],
                          clk_request[2], s_q.sleep);
    if (!s_d.run[2]) begin
      s_d.rdy[2] = 1'b0;                                        // RULE19
      s_d.cnt_i  = '0;
    end else if (!s_q.run[2]) begin
      s_d.cnt_i  = oec_su_len(
        s_q.i32_ctrl[oec_pkg::STARTUP_LSB +: oec_pkg::STARTUP_W]);
      s_d.rdy[2] = 1'b0;
    end else if (s_q.cnt_i != '0) begin
      s_d.cnt_i = s_q.cnt_i - 1'b1;
    end else begin
      s_d.rdy[2] = 1'b1;                                        // RULE17
    end
    // Commit calibration only on the ready rise
    if (s_d.rdy[2] && !s_q.rdy[2]) begin
      s_d.calibration_value = s_q.i32_ctrl[oec_pkg::CALIBRATION_VALUE_LSB +: oec_pkg::CALIBRATION_VALUE_W]; // RULE18
    end
    s_d.run[1] = c_q.run;

    // Sticky flags: a set in the clearing cycle wins
    rdy_all = {s_d.rdy[2], 1'b0, s_d.rdy[0]};
    rise    = rdy_all & ~s_q.rdy;
    // Slow crystal edge kept in its own domain: no false rise on reset
    rise[1] = c_q.rdy & ~c_q.rdy_seen;
    s_d.rdy[1] = c_q.rdy;
    s_d.flag   = s_d.flag | rise;                               // RULE10
    s_d.irq    = |(s_d.flag & s_d.mask);

    // Register reads
    if (rd_en) begin
      s_d.pready = 1'b1;
      case (paddr)
        oec_pkg::MPX_CTRL_OFF:   s_d.prdata = s_q.mpx_ctrl;
        oec_pkg::C32_CTRL_OFF:   s_d.prdata = c_q.c32_ctrl;
        oec_pkg::I32_CTRL_OFF:   s_d.prdata = s_q.i32_ctrl;
        oec_pkg::STATUS_OFF:     s_d.prdata = {29'h0, s_q.rdy};
        oec_pkg::INT_FLAG_OFF:   s_d.prdata = {29'h0, s_q.flag};
        oec_pkg::INT_MASK_OFF:   s_d.prdata = {29'h0, s_q.mask};
        oec_pkg::SLEEP_CTRL_OFF: s_d.prdata = {30'h0, s_q.sleep};
        default: begin
          s_d.prdata  = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (map_hit) begin
      s_d.pslverr = 1'b0;
    end
  end

  // 32k crystal: stays on in every sleep mode once enabled
  always_comb begin
    c_d = c_q;
    if (wr_en && paddr == oec_pkg::C32_CTRL_OFF) begin
      c_d.c32_ctrl = pwdata;                                    // RULE12
    end
    c_d.run = c_q.c32_ctrl[oec_pkg::ENABLE_BIT];                // RULE13
    if (!c_d.run) begin
      c_d.rdy = 1'b0;                                           // RULE19
      c_d.cnt = '0;
    end else if (!c_q.run) begin
      c_d.cnt = oec_su_len(
        c_q.c32_ctrl[oec_pkg::STARTUP_LSB +: oec_pkg::STARTUP_W]);
      c_d.rdy = 1'b0;
    end else if (c_q.cnt != '0) begin
      c_d.cnt = c_q.cnt - 1'b1;
    end else begin
      c_d.rdy = 1'b1;                                           // RULE10
    end
    // Edge memory lives here so a system reset cannot fake a rise
    c_d.rdy_seen = c_q.rdy;
    // Registered copies keep pin and output enables glitch free
    c_d.oovr  = c_d.run & c_d.c32_ctrl[oec_pkg::XTAL_BIT];      // RULE11
    c_d.out32 = c_d.rdy & c_d.c32_ctrl[oec_pkg::XTAL_BIT] &
                c_d.c32_ctrl[oec_pkg::OUTPUT_32K_ENABLE_BIT];               // RULE15
    c_d.ulp   = 1'b1;                                           // RULE3
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Ordinary reset domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.mpx_ctrl <= oec_pkg::CTRL_RESET;                      // RULE4
      s_q.i32_ctrl <= oec_pkg::CTRL_RESET;                      // RULE2
    end else begin
      s_q <= s_d;
    end
  end

  // Power-on reset only, so the slow crystal survives other resets
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      c_q          <= '0;
      c_q.c32_ctrl <= oec_pkg::CTRL_RESET;                      // RULE11
      c_q.ulp      <= 1'b1;                                     // RULE3
    end else begin
      c_q <= c_d;                                               // RULE14
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Input pin overrides follow the run state; output pin overrides also need the mode bit
  logic mpx_xtal;
  logic c32_xtal;
  assign mpx_xtal = s_q.mpx_ctrl[oec_pkg::XTAL_BIT];            // RULE6
  assign c32_xtal = c_q.c32_ctrl[oec_pkg::XTAL_BIT];            // RULE6
  assign prdata   = s_q.prdata;
  assign pready   = s_q.pready;
  assign pslverr  = s_q.pslverr;
  assign irq      = s_q.irq;
  assign mpx_osc_run   = s_q.run[0];
  assign mpx_clk_gate  = s_q.rdy[0];                            // RULE9
  assign mpx_crystal_input_pin_ovr  = s_q.run[0];               // RULE5
  assign mpx_crystal_output_pin_ovr = s_q.mpx_oovr;             // RULE5
  assign mpx_xtal_mode = mpx_xtal;
  assign mpx_auto_amp  = s_q.mpx_ctrl[oec_pkg::AUTO_AMPLITUDE_CONTROL_BIT];      // RULE8
  assign mpx_gain      = s_q.mpx_ctrl[oec_pkg::GAIN_LSB +: oec_pkg::GAIN_W];
  assign c32_osc_run   = c_q.run;
  assign c32_clk_gate  = c_q.rdy;
  assign c32_out_32k_en = c_q.out32;                            // RULE15
  assign slow_crystal_input_pin_ovr  = c_q.run;                 // RULE11
  assign slow_crystal_output_pin_ovr = c_q.oovr;                // RULE11
  assign i32_osc_run   = s_q.run[2];
  assign i32_clk_gate  = s_q.rdy[2];                            // RULE17
  assign i32_calibration_value     = s_q.calibration_value;
  assign ulp_osc_run   = c_q.ulp;                               // RULE3

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !por_n);

  run_needs_en_a: assert property (                           // RULE1
    s_q.run[0] |-> $past(s_q.mpx_ctrl[oec_pkg::ENABLE_BIT]))
    else $error("oscillator running while disabled");
  standby_stop_a: assert property (                           // RULE3
    s_q.sleep == oec_pkg::SLEEP_STANDBY |=> !s_q.run[0] && !s_q.run[2])
    else $error("oscillator running in standby");
  idle_demand_a: assert property (                            // RULE2
    (s_q.sleep == oec_pkg::SLEEP_IDLE && s_q.mpx_ctrl[oec_pkg::ONDEM_BIT]
     && !clk_request[0]) |=> !s_q.run[0])
    else $error("on-demand oscillator ran without request");
  crystal_output_pin_ovr_a: assert property (                               // RULE5
    mpx_crystal_output_pin_ovr |-> mpx_crystal_input_pin_ovr && mpx_xtal)
    else $error("output pin taken in external clock mode");
  mask_startup_a: assert property (                           // RULE9
    $rose(s_q.run[0]) |-> !mpx_clk_gate [*2])
    else $error("clock unmasked during start-up");
  ready_irq_a: assert property (                              // RULE10
    $rose(s_q.rdy[0]) |-> s_q.flag[0])
    else $error("ready rise did not set flag");
  irq_level_a: assert property (                              // RULE10
    irq == |(s_q.flag & s_q.mask))
    else $error("interrupt level wrong");
  standby_c32_a: assert property (                            // RULE13
    c_q.c32_ctrl[oec_pkg::ENABLE_BIT] |=> c_q.run)
    else $error("slow crystal stopped while enabled");
  output_32k_enable_a: assert property (                                  // RULE15
    c32_out_32k_en |-> c32_xtal)
    else $error("32k output in external clock mode");
  i32_both_a: assert property (                               // RULE16
    s_q.run[2] |-> $past(s_q.i32_ctrl[oec_pkg::ENABLE_BIT] &
                         s_q.i32_ctrl[oec_pkg::OUTPUT_32K_ENABLE_BIT]))
    else $error("internal 32k ran without both enables");
  calibration_value_commit_a: assert property (                           // RULE18
    !$rose(s_q.rdy[2]) && !$past(!s_q.rdy[2] && s_d.rdy[2])
      |-> $stable(s_q.calibration_value))
    else $error("calibration changed outside ready rise");
  rdy_clear_a: assert property (                              // RULE19
    !s_q.run[0] |-> !s_q.rdy[0])
    else $error("ready held while disabled");
  // Stop on disable, pin ownership, sticky flags, gating, always-on
  mpx_stop_a: assert property (                               // RULE1
    !s_q.mpx_ctrl[oec_pkg::ENABLE_BIT] |=> !s_q.run[0])
    else $error("oscillator kept running after disable");
  c32_pins_a: assert property (                               // RULE11
    slow_crystal_output_pin_ovr |->
      slow_crystal_input_pin_ovr && c32_xtal)
    else $error("slow output pin taken in external clock mode");
  flag_hold_a: assert property (                              // RULE10
    s_q.flag[0] && !(wr_en && paddr == oec_pkg::INT_FLAG_OFF && pwdata[0])
      |=> s_q.flag[0])
    else $error("interrupt flag lost without a clear");
  i32_gate_a: assert property (                               // RULE17
    i32_clk_gate |-> i32_osc_run)
    else $error("internal 32k clock passed while stopped");
  ulp_run_a: assert property (                                // RULE3
    ulp_osc_run)
    else $error("always-on oscillator stopped");

  mpx_ready_c: cover property ($rose(s_q.rdy[0]));
  stby_c32_c: cover property (
    s_q.sleep == oec_pkg::SLEEP_STANDBY && c_q.run);
  c32_ready_c: cover property ($rose(c_q.rdy));
  i32_commit_c: cover property ($rose(s_q.rdy[2]));
  irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// ---- verification/oec_osc_model.sv ----
// Behavioural crystal or external clock source at the oscillator pins
`timescale 1ns/1ps
`default_nettype none
module oec_osc_model #(
  parameter int HALF_NS = 31
) (
  // Pin ownership from the block
  input  wire logic run,
  input  wire logic in_ovr,
  input  wire logic out_ovr,
  // Pin levels seen by the pad
  output logic      crystal_input_pin,
  output logic      crystal_output_pin
);
  logic osc = 1'b0;

  // Source swings all the time; owned and free pins carry it in opposite phase
  initial begin
    forever begin
      #(HALF_NS);
      osc = ~osc;
    end
  end

  // A free pin shows a changing pattern, never a stale level
  assign crystal_input_pin  = (run && in_ovr) ? osc : ~osc;
  assign crystal_output_pin = (run && out_ovr) ? ~osc : osc;
endmodule
`default_nettype wire

// ---- verification/oec_top_tb.sv ----
// Self-checking bench for the oscillator enable control block
`timescale 1ns/1ps
`default_nettype none
module oec_top_tb;
  localparam logic [31:0] EN  = 32'h1 << oec_pkg::ENABLE_BIT;
  localparam logic [31:0] XT  = 32'h1 << oec_pkg::XTAL_BIT;
  localparam logic [31:0] E32 = 32'h1 << oec_pkg::OUTPUT_32K_ENABLE_BIT;
  localparam logic [31:0] AG  = 32'h1 << oec_pkg::AUTO_AMPLITUDE_CONTROL_BIT;
  localparam logic [31:0] OD  = 32'h1 << oec_pkg::ONDEM_BIT;
  logic        pclk = 1'b0, presetn = 1'b0, por_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  clk_request = 3'h0, mpx_gain;
  logic [6:0]  i32_calibration_value;
  logic        pready, pslverr, err, irq, ulp_osc_run;
  logic        mpx_osc_run, mpx_clk_gate, mpx_xtal_mode, mpx_auto_amp;
  logic        mpx_crystal_input_pin_ovr, mpx_crystal_output_pin_ovr;
  logic        c32_osc_run, c32_clk_gate, c32_out_32k_en;
  logic        slow_crystal_input_pin_ovr, slow_crystal_output_pin_ovr;
  logic        i32_osc_run, i32_clk_gate;
  int          mismatches = 0, checked = 0, cyc = 0;

  oec_top i_dut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .clk_request,
    .mpx_osc_run, .mpx_clk_gate, .mpx_crystal_input_pin_ovr,
    .mpx_crystal_output_pin_ovr, .mpx_xtal_mode, .mpx_auto_amp,
    .mpx_gain, .c32_osc_run, .c32_clk_gate, .c32_out_32k_en,
    .slow_crystal_input_pin_ovr, .slow_crystal_output_pin_ovr,
    .i32_osc_run, .i32_clk_gate, .i32_calibration_value, .ulp_osc_run, .irq);
  oec_osc_model i_src (.run(mpx_osc_run),
    .in_ovr(mpx_crystal_input_pin_ovr),
    .out_ovr(mpx_crystal_output_pin_ovr), .crystal_input_pin(), .crystal_output_pin());

  // Clock at 10 MHz
  initial begin
    forever #50 pclk = ~pclk;
  end

  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge pclk);
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  // Poll status for a ready bit, bounded
  task automatic wait_rdy(input int b);
    repeat (60) begin
      apb(1'b0, oec_pkg::STATUS_OFF, 32'h0);
      if (rd[b] === 1'b1) break;
    end
    chk("ready", 32'h1, 32'(rd[b]));
  endtask

  task automatic t_reset;
    chk("ulp_run", 32'h1, 32'(ulp_osc_run));
    chk("mpx_pins", 32'h0, 32'({mpx_crystal_input_pin_ovr,
        mpx_crystal_output_pin_ovr}));
    chk("c32_pins", 32'h0, 32'({slow_crystal_input_pin_ovr,
        slow_crystal_output_pin_ovr}));
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("ctrl_reset", oec_pkg::CTRL_RESET, rd);
    end
  endtask

  task automatic t_mpx;
    apb(1'b1, oec_pkg::INT_MASK_OFF, 32'h7);
    apb(1'b1, oec_pkg::MPX_CTRL_OFF, EN | XT | AG | OD | 32'h400);
    chk("mpx_run", 32'h1, 32'(mpx_osc_run));
    chk("mpx_gate", 32'h0, 32'(mpx_clk_gate));
    chk("mpx_pins", 32'h3, 32'({mpx_crystal_input_pin_ovr,
        mpx_crystal_output_pin_ovr}));
    chk("mpx_amp", 32'h1, 32'(mpx_auto_amp));
    chk("mpx_mode", 32'h1, 32'(mpx_xtal_mode));
    chk("mpx_gain", 32'h4, 32'(mpx_gain));
    wait_rdy(oec_pkg::MPX_RDY_BIT);
    chk("mpx_gate", 32'h1, 32'(mpx_clk_gate));
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, oec_pkg::INT_FLAG_OFF, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, oec_pkg::MPX_CTRL_OFF, EN | OD);
    chk("mpx_pins", 32'h2, 32'({mpx_crystal_input_pin_ovr,
        mpx_crystal_output_pin_ovr}));
    chk("mpx_mode", 32'h0, 32'(mpx_xtal_mode));
    chk("mpx_amp", 32'h0, 32'(mpx_auto_amp));
    apb(1'b1, oec_pkg::MPX_CTRL_OFF, OD);
    chk("mpx_run", 32'h0, 32'(mpx_osc_run));
    apb(1'b0, oec_pkg::STATUS_OFF, 32'h0);
    chk("mpx_rdy", 32'h0, 32'(rd[0]));
  endtask

  task automatic t_idle;
    apb(1'b1, oec_pkg::SLEEP_CTRL_OFF, 32'(oec_pkg::SLEEP_IDLE));
    apb(1'b1, oec_pkg::MPX_CTRL_OFF, EN | OD);
    tick(2);
    chk("idle_norq", 32'h0, 32'(mpx_osc_run));
    @(posedge pclk);
    clk_request <= 3'h1;
    tick(3);
    chk("idle_rq", 32'h1, 32'(mpx_osc_run));
    @(posedge pclk);
    clk_request <= 3'h0;
    apb(1'b1, oec_pkg::MPX_CTRL_OFF, EN);
    tick(2);
    chk("idle_on", 32'h1, 32'(mpx_osc_run));
    apb(1'b1, oec_pkg::SLEEP_CTRL_OFF, 32'(oec_pkg::SLEEP_STANDBY));
    tick(2);
    chk("stby_run", 32'h0, 32'(mpx_osc_run));
    chk("ulp_run", 32'h1, 32'(ulp_osc_run));
    apb(1'b1, oec_pkg::SLEEP_CTRL_OFF, 32'(oec_pkg::SLEEP_ACTIVE));
    tick(2);
    chk("wake_gate", 32'h0, 32'(mpx_clk_gate));
    wait_rdy(oec_pkg::MPX_RDY_BIT);
    apb(1'b1, oec_pkg::MPX_CTRL_OFF, OD);
  endtask

  task automatic t_c32;
    apb(1'b1, oec_pkg::INT_FLAG_OFF, 32'h7);
    apb(1'b1, oec_pkg::INT_MASK_OFF, 32'h5);
    apb(1'b1, oec_pkg::C32_CTRL_OFF, XT | E32 | OD);
    apb(1'b1, oec_pkg::C32_CTRL_OFF, EN | XT | E32 | OD);
    chk("c32_pins", 32'h3, 32'({slow_crystal_input_pin_ovr,
        slow_crystal_output_pin_ovr}));
    wait_rdy(oec_pkg::C32_RDY_BIT);
    tick(1);
    chk("c32_out", 32'h1, 32'(c32_out_32k_en));
    chk("irq_mask", 32'h0, 32'(irq));
    apb(1'b1, oec_pkg::INT_MASK_OFF, 32'h7);
    tick(1);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, oec_pkg::SLEEP_CTRL_OFF, 32'(oec_pkg::SLEEP_STANDBY));
    tick(2);
    chk("c32_stby", 32'h1, 32'(c32_osc_run));
    @(posedge pclk);
    presetn <= 1'b0;
    tick(2);
    @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    chk("c32_keep", 32'h1, 32'(c32_clk_gate));
    apb(1'b1, oec_pkg::C32_CTRL_OFF, XT | E32 | OD);
    tick(1);
    chk("c32_off", 32'h0, 32'(c32_osc_run));
    apb(1'b1, oec_pkg::C32_CTRL_OFF, E32 | OD);
    apb(1'b1, oec_pkg::C32_CTRL_OFF, EN | E32 | OD);
    wait_rdy(oec_pkg::C32_RDY_BIT);
    chk("c32_ext", 32'h2, 32'({slow_crystal_input_pin_ovr,
        slow_crystal_output_pin_ovr}));
    chk("c32_out", 32'h0, 32'(c32_out_32k_en));
    @(posedge pclk);
    por_n <= 1'b0;
    tick(2);
    @(posedge pclk);
    por_n <= 1'b1;
    tick(1);
    chk("c32_por", 32'h0, 32'(c32_osc_run));
    apb(1'b0, oec_pkg::C32_CTRL_OFF, 32'h0);
    chk("c32_ctrl", oec_pkg::CTRL_RESET, rd);
    chk("ulp_por", 32'h1, 32'(ulp_osc_run));
  endtask

  task automatic t_i32;
    apb(1'b1, oec_pkg::I32_CTRL_OFF, EN | OD);
    tick(2);
    chk("i32_half", 32'h0, 32'(i32_osc_run));
    apb(1'b1, oec_pkg::I32_CTRL_OFF, EN | E32 | OD | 32'h0055_0000);
    chk("i32_gate", 32'h0, 32'(i32_clk_gate));
    chk("i32_cal", 32'h0, 32'(i32_calibration_value));
    wait_rdy(oec_pkg::I32_RDY_BIT);
    tick(1);
    chk("i32_gate", 32'h1, 32'(i32_clk_gate));
    chk("i32_cal", 32'h55, 32'(i32_calibration_value));
    apb(1'b1, oec_pkg::I32_CTRL_OFF, E32 | OD);
    apb(1'b0, oec_pkg::STATUS_OFF, 32'h0);
    chk("i32_rdy", 32'h0, 32'(rd[2]));
  endtask

  task automatic t_err;
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("bad_rd", 32'h0, rd);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    tick(1);
    t_reset();
    t_mpx();
    t_idle();
    t_c32();
    t_i32();
    t_err();
    conclude();
  end
endmodule
`default_nettype wire
